// file: rtl/dxs_pkg.sv
package dxs_pkg;
    // ************************************************************
    // debug register selection codes
    // ************************************************************
    localparam logic [4:0] DRC_EXT  = 5'h01;
    localparam logic [4:0] DRC_CFG2 = 5'h02;

    // ************************************************************
    // extended register fields
    // ************************************************************
    localparam int EXT_HALT_BIT   = 31;
    localparam int EXT_STOP_BIT   = 30;
    localparam int EXT_STAT_LSB   = 27;
    localparam int EXT_CLKSEL_BIT = 26;
    localparam int EXT_SEC_BIT    = 25;
    localparam int EXT_BGEN_BIT   = 24;
    localparam int EXT_SYNEN_BIT  = 2;
    localparam int EXT_SYNSEL_LSB = 0;
    localparam logic [2:0] ERASE_SEQ_USER_MASS = 3'h0;

    // ************************************************************
    // second configuration register fields
    // ************************************************************
    localparam int CFG2_STOPF_BIT = 31;
    localparam int CFG2_WDHR_BIT  = 29;
    localparam int CFG2_IOHR_BIT  = 28;
    localparam int CFG2_IAHR_BIT  = 27;
    localparam int CFG2_DRHR_BIT  = 25;
    localparam int CFG2_FRST_BIT  = 24;
    localparam int CFG2_FULLH_BIT = 23;
    localparam int CFG2_TST_LSB   = 21;
    localparam int CFG2_REV_LSB   = 16;
    localparam int CFG2_DIV16_BIT = 6;
    localparam logic [23:0] CFG2_LOW_WMASK = 24'h00005F;
    localparam logic [7:0]  CFG2_HIGH_WMASK = 8'h3A;

    // ************************************************************
    // sync timing
    // ************************************************************
    localparam int SYNC_BASE_CYCLES = 1024;
    localparam int SYNC_DIV_SHIFT   = 4;
    localparam int SYNC_CNT_W       = 15;

    typedef enum logic [1:0] {
        DXS_ERS_IDLE  = 2'b00,
        DXS_ERS_START = 2'b01,
        DXS_ERS_BUSY  = 2'b11
    } dxs_erase_st_t;
endpackage

// file: rtl/dxs_sync_timer.sv
`timescale 1ns/100ps
module dxs_sync_timer
    import dxs_pkg::*;
#(
    parameter int CNT_W = SYNC_CNT_W
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic [1:0] interval_sel,
    input  wire logic       div16,
    output logic            sync_pulse
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // period = 2^(sel+1)*1024 >> 4*div16
    function automatic logic [CNT_W-1:0] period_of(input logic [1:0] sel, input logic d);
        logic [CNT_W:0] p;
        // shift amount kept 3 bits wide, sel 3 plus one must not wrap to zero
        p = (CNT_W+1)'(SYNC_BASE_CYCLES) << ({1'b0, sel} + 3'h1);
        if (d) begin
            p = p >> SYNC_DIV_SHIFT;
        end
        period_of = CNT_W'(p - 1'b1);
    endfunction

    assign limit = period_of(interval_sel, div16);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count      <= '0;
            sync_pulse <= 1'b0;
        end else if (!enable) begin // [R24]
            count      <= '0;
            sync_pulse <= 1'b0;
        end else if (count >= limit) begin // [R16] [R17] [R23]
            count      <= '0;
            sync_pulse <= 1'b1;
        end else begin
            count      <= count + 1'b1;
            sync_pulse <= 1'b0;
        end
    end

    property p_sync_period;
        @(posedge clk) disable iff (!rst_n)
        (enable && !div16 && interval_sel == 2'b00 && sync_pulse) ##1
        (enable && !div16 && interval_sel == 2'b00) [*8] |-> !sync_pulse;
    endproperty
    a_sync_period: assert property (p_sync_period) else $error("sync too early"); // [R16]

    property p_no_sync_disabled;
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !sync_pulse;
    endproperty
    a_no_sync_disabled: assert property (p_no_sync_disabled) else $error("sync while off"); // [R17]

    c_sync: cover property (@(posedge clk) disable iff (!rst_n) sync_pulse);
endmodule

// file: rtl/dxs_top.sv
`timescale 1ns/100ps
// Summary of operation
// (R1) 32-bit extended register, status byte always reachable
// (R2) byte commands touch bits 31..24, any mode
// (R3) generic read 32 bits, write 23..0
// (R4) privileged write updates bits 23..0 only
// (R5) code 0x01; supervisor write-only, channel read/write
// (R6) bits 31/30 report halted/stopped CPU
// (R7) bits 29..27 read command status
// (R8) host recovers overrun by resync, nop, reread; host model only rereads status, no resync or nop
// (R9) write 29..27 selects erase sequence
// (R10) bit 26 selects debug channel clock
// (R11) clock select loaded from pin at reset
// (R12) bit 25 reads security or erase busy
// (R13) writing one to bit 25 starts erase
// (R14) bit 24 enables background mode if unsecured
// (R15) reserved bits 23..3 read zero, no function
// (R16) sync period 2^(sel+1)*1024, optional /16
// (R17) enabled interval expiry issues pc sync
// (R18) sync forces fetch; trace marker plus address
// (R19) second register 32 bits, upper status byte
// (R20) second register access widths as first
// (R21) code 0x02; supervisor read-only, channel read/write
// (R22) halt-after-reset bits clear only on power-on
// (R23) divider option scales sync counts by 16
// (R24) sync counter restarts, clears when disabled
// (R25) read-only or out-of-range bits ignore writes
module dxs_top
    import dxs_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h1 // arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        POR_N,
    input  wire logic        BACKGROUND_PIN_LEVEL,
    input  wire logic        CH_VALID,
    input  wire logic        CH_WRITE,
    input  wire logic        CH_BYTE,
    input  wire logic [4:0]  CH_CODE,
    input  wire logic [31:0] CH_WDATA,
    output logic      [31:0] CH_RDATA,
    output logic             CH_RVALID,
    input  wire logic        SUP_WE,
    input  wire logic        SUP_RE,
    input  wire logic [4:0]  SUP_CODE,
    input  wire logic [31:0] SUP_WDATA,
    output logic      [31:0] SUP_RDATA,
    input  wire logic        CPU_HALTED,
    input  wire logic        CPU_STOPPED,
    input  wire logic [2:0]  CMD_STATUS,
    input  wire logic        FLASH_SECURED,
    input  wire logic        FLASH_ERASE_DONE,
    input  wire logic        TRACE_STOP,
    input  wire logic        TRACE_FULL_HALT,
    input  wire logic [1:0]  TRACE_STATE,
    input  wire logic        BRANCH_TARGET_3B,
    output logic             ERASE_START,
    output logic [2:0]       ERASE_SEQ,
    output logic             DEBUG_CLK_SYNC,
    output logic             BG_MODE_ACTIVE,
    output logic             PC_SYNC_CMD,
    output logic             PC_SYNC_3BYTE,
    output logic             FORCE_DEBUG_RESET,
    output logic [3:0]       HALT_AFTER_RESET,
    output logic [23:0]      CFG2_LOW
);
    // ************************************************************
    // write decode
    // ************************************************************
    logic          ch_ext_w;
    logic          ch_cfg2_w;
    logic          sup_ext_w;
    logic          clksel;
    logic          bg_en;
    logic [1:0]    sync_sel;
    logic          sync_en;
    logic          div16;
    logic [3:0]    halt_rst;
    logic          rst_prev;
    logic          sync_pulse;
    logic          erase_busy;
    dxs_erase_st_t erase_st;
    dxs_erase_st_t next_erase_st;
    logic          erase_req;
    logic [31:0]   ext_view;
    logic [31:0]   cfg2_view;

    // channel writes need byte or generic; supervisor only writes reg 0x01
    assign ch_ext_w  = CH_VALID && CH_WRITE && CH_CODE == DRC_EXT;    // [R5]
    assign ch_cfg2_w = CH_VALID && CH_WRITE && CH_CODE == DRC_CFG2;   // [R21]
    assign sup_ext_w = SUP_WE && SUP_CODE == DRC_EXT;                 // [R4] [R5]
    assign erase_req = ch_ext_w && CH_BYTE && CH_WDATA[EXT_SEC_BIT];  // [R13]

    // ************************************************************
    // extended register: upper byte via byte command only
    // ************************************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bg_en <= 1'b0;
        end else if (ch_ext_w && CH_BYTE) begin // [R2] [R14]
            bg_en <= CH_WDATA[EXT_BGEN_BIT];
        end
    end

    // strap capture after release, never in the async branch
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_prev <= 1'b1;
            clksel   <= 1'b0;
        end else begin
            rst_prev <= 1'b0;
            if (rst_prev) begin // [R11]
                clksel <= BACKGROUND_PIN_LEVEL;
            end else if (ch_ext_w && CH_BYTE) begin // [R10]
                clksel <= CH_WDATA[EXT_CLKSEL_BIT];
            end
        end
    end

    // lower bits: generic channel write or supervisor write
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_sel <= 2'h0;
            sync_en  <= 1'b0;
        end else if (ch_ext_w && !CH_BYTE) begin // [R3] [R15]
            sync_sel <= CH_WDATA[EXT_SYNSEL_LSB +: 2];
            sync_en  <= CH_WDATA[EXT_SYNEN_BIT];
        end else if (sup_ext_w) begin // [R4]
            sync_sel <= SUP_WDATA[EXT_SYNSEL_LSB +: 2];
            sync_en  <= SUP_WDATA[EXT_SYNEN_BIT];
        end
    end

    // ************************************************************
    // mass erase sequencing
    // ************************************************************
    always_comb begin
        next_erase_st = erase_st;
        case (erase_st)
            DXS_ERS_IDLE: begin
                // reserved sequence codes are ignored
                if (erase_req && CH_WDATA[EXT_STAT_LSB +: 3] == ERASE_SEQ_USER_MASS) begin // [R9]
                    next_erase_st = DXS_ERS_START;
                end
            end
            DXS_ERS_START: begin
                next_erase_st = DXS_ERS_BUSY;
            end
            DXS_ERS_BUSY: begin
                if (FLASH_ERASE_DONE) begin
                    next_erase_st = DXS_ERS_IDLE;
                end
            end
            default: begin
                next_erase_st = DXS_ERS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            erase_st <= DXS_ERS_IDLE;
        end else begin
            erase_st <= next_erase_st;
        end
    end

    assign erase_busy = erase_st != DXS_ERS_IDLE; // [R12]

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ERASE_START <= 1'b0;
            ERASE_SEQ   <= ERASE_SEQ_USER_MASS;
        end else begin
            ERASE_START <= erase_st == DXS_ERS_IDLE && next_erase_st == DXS_ERS_START; // [R13]
            if (erase_req) begin
                ERASE_SEQ <= CH_WDATA[EXT_STAT_LSB +: 3];
            end
        end
    end

    // ************************************************************
    // second configuration register
    // ************************************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CFG2_LOW <= 24'h000000;
        end else if (ch_cfg2_w && !CH_BYTE) begin // [R20] [R25]
            CFG2_LOW <= CH_WDATA[23:0] & CFG2_LOW_WMASK;
        end
    end
    assign div16 = CFG2_LOW[CFG2_DIV16_BIT];

    // halt-after-reset bits survive every reset but power-on
    always_ff @(posedge CLK or negedge POR_N) begin
        if (!POR_N) begin
            halt_rst <= 4'h0; // [R22]
        end else if (ch_cfg2_w && CH_BYTE && bg_en && !FLASH_SECURED) begin
            halt_rst <= {CH_WDATA[CFG2_WDHR_BIT], CH_WDATA[CFG2_IOHR_BIT],
                         CH_WDATA[CFG2_IAHR_BIT], CH_WDATA[CFG2_DRHR_BIT]};
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FORCE_DEBUG_RESET <= 1'b0;
            HALT_AFTER_RESET  <= 4'h0;
        end else begin
            // reads back as zero; pulse only
            FORCE_DEBUG_RESET <= ch_cfg2_w && CH_BYTE && CH_WDATA[CFG2_FRST_BIT];
            HALT_AFTER_RESET  <= halt_rst;
        end
    end

    // ************************************************************
    // pc sync generation
    // ************************************************************
    dxs_sync_timer u_timer (
        .clk          (CLK),
        .rst_n        (RST_N),
        .enable       (sync_en),
        .interval_sel (sync_sel),
        .div16        (div16),
        .sync_pulse   (sync_pulse)
    );

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PC_SYNC_CMD   <= 1'b0;
            PC_SYNC_3BYTE <= 1'b0;
        end else begin
            PC_SYNC_CMD   <= sync_pulse && sync_en; // [R17] [R18]
            PC_SYNC_3BYTE <= BRANCH_TARGET_3B;      // [R18]
        end
    end

    // ************************************************************
    // read views and outputs
    // ************************************************************
    assign ext_view = {CPU_HALTED, CPU_STOPPED, CMD_STATUS, clksel,          // [R6] [R7]
                       erase_busy | FLASH_SECURED, bg_en,                    // [R12]
                       21'h000000, sync_en, sync_sel};                       // [R1] [R15]
    assign cfg2_view = {TRACE_STOP, 1'b0, halt_rst[3:1], 1'b0, halt_rst[0], 1'b0, // [R19]
                        TRACE_FULL_HALT, TRACE_STATE, 1'b0, REVISION_CODE, CFG2_LOW[15:0]};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CH_RDATA  <= 32'h00000000;
            CH_RVALID <= 1'b0;
            SUP_RDATA <= 32'h00000000;
        end else begin
            CH_RVALID <= CH_VALID && !CH_WRITE;
            if (CH_VALID && !CH_WRITE) begin // [R2] [R3]
                case (CH_CODE)
                    DRC_EXT:  CH_RDATA <= CH_BYTE ? {ext_view[31:24], 24'h000000} : ext_view;
                    DRC_CFG2: CH_RDATA <= CH_BYTE ? {cfg2_view[31:24], 24'h000000} : cfg2_view;
                    default:  CH_RDATA <= 32'h00000000;
                endcase
            end
            // supervisor cannot read the extended register
            SUP_RDATA <= (SUP_RE && SUP_CODE == DRC_CFG2) ? cfg2_view : 32'h00000000; // [R5] [R21]
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DEBUG_CLK_SYNC <= 1'b0;
            BG_MODE_ACTIVE <= 1'b0;
        end else begin
            DEBUG_CLK_SYNC <= clksel;
            BG_MODE_ACTIVE <= bg_en && !FLASH_SECURED; // [R14]
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_bg_secure;
        @(posedge CLK) disable iff (!RST_N)
        FLASH_SECURED |=> !BG_MODE_ACTIVE;
    endproperty
    a_bg_secure: assert property (p_bg_secure) else $error("bg active while secured"); // [R14]

    property p_sup_no_ext_read;
        @(posedge CLK) disable iff (!RST_N)
        SUP_RE && SUP_CODE == DRC_EXT |=> SUP_RDATA == 32'h00000000;
    endproperty
    a_sup_no_ext_read: assert property (p_sup_no_ext_read) else $error("sup read ext"); // [R5]

    property p_byte_read;
        @(posedge CLK) disable iff (!RST_N)
        CH_VALID && !CH_WRITE && CH_BYTE |=> CH_RVALID && CH_RDATA[23:0] == 24'h000000;
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("byte read width"); // [R2]

    property p_sup_low_only;
        @(posedge CLK) disable iff (!RST_N)
        sup_ext_w && !ch_ext_w && !rst_prev |=> $stable(bg_en) && $stable(clksel);
    endproperty
    a_sup_low_only: assert property (p_sup_low_only) else $error("sup wrote upper"); // [R4]

    property p_generic_low_only;
        @(posedge CLK) disable iff (!RST_N)
        ch_ext_w && !CH_BYTE && !rst_prev |=> $stable(bg_en) && $stable(clksel);
    endproperty
    a_generic_low_only: assert property (p_generic_low_only) else $error("generic upper"); // [R3]

    property p_erase_busy;
        @(posedge CLK) disable iff (!RST_N)
        ERASE_START |-> erase_busy ##1 ext_view[EXT_SEC_BIT];
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("busy not shown"); // [R12]

    property p_erase_start;
        @(posedge CLK) disable iff (!RST_N)
        erase_req && erase_st == DXS_ERS_IDLE
        && CH_WDATA[EXT_STAT_LSB +: 3] == ERASE_SEQ_USER_MASS
        |=> ERASE_START;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase not started"); // [R13]

    property p_status_map;
        @(posedge CLK) disable iff (!RST_N)
        CH_VALID && !CH_WRITE && CH_CODE == DRC_EXT
        |=> CH_RDATA[31:27] == $past({CPU_HALTED, CPU_STOPPED, CMD_STATUS});
    endproperty
    a_status_map: assert property (p_status_map) else $error("status map"); // [R6] [R7]

    property p_clksel_strap;
        @(posedge CLK) disable iff (!RST_N)
        rst_prev |=> clksel == $past(BACKGROUND_PIN_LEVEL);
    endproperty
    a_clksel_strap: assert property (p_clksel_strap) else $error("strap not loaded"); // [R11]

    property p_halt_locked;
        @(posedge CLK) disable iff (!RST_N)
        ch_cfg2_w && CH_BYTE && !(bg_en && !FLASH_SECURED) |=> $stable(halt_rst);
    endproperty
    a_halt_locked: assert property (p_halt_locked) else $error("halt bits unlocked"); // [R22] [R25]

    c_erase: cover property (@(posedge CLK) disable iff (!RST_N) ERASE_START);
    c_pcsync: cover property (@(posedge CLK) disable iff (!RST_N) PC_SYNC_CMD);
    // code is released with the request, so look one cycle back
    c_cfg2rd: cover property (@(posedge CLK) disable iff (!RST_N)
        CH_RVALID && $past(CH_CODE) == DRC_CFG2);
endmodule

// file: verification/dxs_host_model.sv
`timescale 1ns/100ps
// ****************
// serial debug host
// ****************
module dxs_host_model (
    input  wire logic        clk,
    output logic             ch_valid,
    output logic             ch_write,
    output logic             ch_byte,
    output logic [4:0]       ch_code,
    output logic [31:0]      ch_wdata,
    input  wire logic [31:0] ch_rdata,
    input  wire logic        ch_rvalid
);
    initial begin
        ch_valid = 1'b0;
        ch_write = 1'b0;
        ch_byte  = 1'b0;
        ch_code  = 5'h1F;
        ch_wdata = 32'h5A5A5A5A;
    end

    task automatic xfer(input logic wr, input logic byt, input logic [4:0] code,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        rd = 'x;
        if (wr && !byt && code == 5'h01)
            wd[23:3] = 21'h0;
        @(posedge clk);
        ch_valid <= 1'b1;
        ch_write <= wr;
        ch_byte  <= byt;
        ch_code  <= code;
        ch_wdata <= wd;
        @(posedge clk);
        ch_valid <= 1'b0;
        ch_code  <= ~code;
        // released data flips so stale values never pass
        ch_wdata <= ~wd;
        if (!wr) begin
            n = 0;
            #1;
            while (ch_rvalid !== 1'b1 && n < 4) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (ch_rvalid === 1'b1)
                rd = ch_rdata;
        end
    endtask

    // overrun recovery poll; resync and nop have no port here, caller escalates
    task automatic status_ok(output logic ok);
        logic [31:0] r;
        xfer(1'b0, 1'b1, 5'h01, 32'h0, r);
        ok = (r[29:27] === 3'b000);
    endtask
endmodule

// file: verification/dxs_top_test.sv
`timescale 1ns/100ps
module dxs_top_test;
    import dxs_pkg::*;
    localparam logic [3:0] REV = 4'h5; // arbitrary value
    logic        CLK, RST_N, POR_N, BACKGROUND_PIN_LEVEL, CH_VALID, CH_WRITE, CH_BYTE, CH_RVALID;
    logic [4:0]  CH_CODE, SUP_CODE;
    logic [31:0] CH_WDATA, CH_RDATA, SUP_WDATA, SUP_RDATA, rd, wd;
    logic        SUP_WE, SUP_RE, CPU_HALTED, CPU_STOPPED, FLASH_SECURED, FLASH_ERASE_DONE;
    logic [2:0]  CMD_STATUS, ERASE_SEQ, ext_low;
    logic        TRACE_STOP, TRACE_FULL_HALT, BRANCH_TARGET_3B, ERASE_START, DEBUG_CLK_SYNC;
    logic        BG_MODE_ACTIVE, PC_SYNC_CMD, PC_SYNC_3BYTE, FORCE_DEBUG_RESET, ok;
    logic [1:0]  TRACE_STATE;
    logic [3:0]  HALT_AFTER_RESET, hexp;
    logic [23:0] CFG2_LOW, c2low;
    logic        ext_clk, ext_bg, busy;
    int          err_total, checked, c, n;

    dxs_top #(.REVISION_CODE(REV)) dxs_top_i (
        .CLK, .RST_N, .POR_N, .BACKGROUND_PIN_LEVEL, .CH_VALID, .CH_WRITE, .CH_BYTE, .CH_CODE,
        .CH_WDATA, .CH_RDATA, .CH_RVALID, .SUP_WE, .SUP_RE, .SUP_CODE, .SUP_WDATA,
        .SUP_RDATA, .CPU_HALTED, .CPU_STOPPED, .CMD_STATUS, .FLASH_SECURED,
        .FLASH_ERASE_DONE, .TRACE_STOP, .TRACE_FULL_HALT, .TRACE_STATE, .BRANCH_TARGET_3B,
        .ERASE_START, .ERASE_SEQ, .DEBUG_CLK_SYNC, .BG_MODE_ACTIVE, .PC_SYNC_CMD,
        .PC_SYNC_3BYTE, .FORCE_DEBUG_RESET, .HALT_AFTER_RESET, .CFG2_LOW
    );
    dxs_host_model dxs_host_model_i (
        .clk(CLK), .ch_valid(CH_VALID), .ch_write(CH_WRITE), .ch_byte(CH_BYTE),
        .ch_code(CH_CODE), .ch_wdata(CH_WDATA), .ch_rdata(CH_RDATA), .ch_rvalid(CH_RVALID)
    );

    // ****************
    // expectations and helpers
    // ****************
    function automatic logic [31:0] ext_exp();
        return {CPU_HALTED, CPU_STOPPED, CMD_STATUS, ext_clk, busy | FLASH_SECURED, ext_bg,
                21'h0, ext_low};
    endfunction
    // trace write pointer bits 15..8 are not modelled, callers mask them
    function automatic logic [31:0] cfg2_exp();
        return {TRACE_STOP, 1'b0, hexp[3:1], 1'b0, hexp[0], 1'b0, TRACE_FULL_HALT,
                TRACE_STATE, 1'b0, REV, 8'h0, c2low[7:0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic ch(input logic w, input logic b, input logic [4:0] a, input logic [31:0] d);
        dxs_host_model_i.xfer(w, b, a, d, rd);
    endtask
    task automatic sup(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        SUP_WE <= w;
        SUP_RE <= !w;
        SUP_CODE <= a;
        SUP_WDATA <= d;
        @(posedge CLK);
        SUP_WE <= 1'b0;
        SUP_RE <= 1'b0;
        SUP_WDATA <= ~d;
        #1;
        rd = SUP_RDATA;
    endtask
    task automatic watch(input int sel, input int k, output int cnt);
        cnt = 0;
        repeat (k) begin
            #1;
            if ((sel == 0 ? ERASE_START : sel == 1 ? PC_SYNC_CMD : FORCE_DEBUG_RESET) === 1'b1)
                cnt++;
            @(posedge CLK);
        end
    endtask
    task automatic gap(output int k);
        int w;
        w = 0;
        while (PC_SYNC_CMD !== 1'b1 && w < 20000) begin
            @(posedge CLK);
            #1;
            w++;
        end
        k = 0;
        do begin
            @(posedge CLK);
            #1;
            k++;
        end while (PC_SYNC_CMD !== 1'b1 && k < 20000);
    endtask
    task automatic report_and_stop();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        repeat (60000) @(posedge CLK);
        err_total++;
        report_and_stop();
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        {RST_N, POR_N, SUP_WE, SUP_RE, FLASH_ERASE_DONE, BRANCH_TARGET_3B} = '0;
        {CPU_HALTED, CPU_STOPPED, CMD_STATUS, FLASH_SECURED, TRACE_STOP} = '0;
        {TRACE_FULL_HALT, TRACE_STATE, SUP_CODE, SUP_WDATA} = '0;
        BACKGROUND_PIN_LEVEL = 1'b1;
        err_total = 0;
        checked = 0;
        void'($urandom(20));
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        POR_N <= 1'b1;
        step(3);
        {ext_clk, ext_bg, busy, ext_low, c2low, hexp} = {3'b100, 3'h0, 24'h0, 4'h0};
        check(32'(DEBUG_CLK_SYNC), 32'h1);
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            CPU_HALTED <= i[0];
            CPU_STOPPED <= !i[0] && 1'($urandom);
            CMD_STATUS <= 3'(i);
            FLASH_SECURED <= 1'($urandom);
            {TRACE_STOP, TRACE_FULL_HALT, TRACE_STATE} <= 4'($urandom);
            step(2);
            ch(1'b0, 1'b0, DRC_EXT, 32'h0);
            check(rd, ext_exp());
            ch(1'b0, 1'b1, DRC_EXT, 32'h0);
            check(rd, ext_exp() & 32'hFF000000);
        end
        dxs_host_model_i.status_ok(ok);
        check(32'(ok), 32'h0);
        FLASH_SECURED <= 1'b0;
        ch(1'b1, 1'b1, DRC_EXT, 32'hFDFFFFFF);
        watch(0, 3, c);
        check(32'(c), 32'h0);
        {ext_clk, ext_bg} = 2'b11;
        check(32'(BG_MODE_ACTIVE), 32'h1);
        ch(1'b0, 1'b0, DRC_EXT, 32'h0);
        check(rd, ext_exp());
        FLASH_SECURED <= 1'b1;
        step(2);
        check(32'(BG_MODE_ACTIVE), 32'h0);
        FLASH_SECURED <= 1'b0;
        ch(1'b1, 1'b0, DRC_EXT, 32'hFE000002);
        ext_low = 3'h2;
        ch(1'b0, 1'b0, DRC_EXT, 32'h0);
        check(rd, ext_exp());
        sup(1'b1, DRC_EXT, 32'h00000003);
        ext_low = 3'h3;
        ch(1'b0, 1'b0, DRC_EXT, 32'h0);
        check(rd, ext_exp());
        sup(1'b0, DRC_EXT, 32'h0);
        check(rd, 32'h0);
        ch(1'b1, 1'b1, DRC_EXT, 32'h02000000);
        watch(0, 3, c);
        check(32'(c), 32'h1);
        check(32'(ERASE_SEQ), 32'(ERASE_SEQ_USER_MASS));
        {ext_clk, ext_bg, busy} = 3'b001;
        check(32'(DEBUG_CLK_SYNC), 32'h0);
        ch(1'b0, 1'b0, DRC_EXT, 32'h0);
        check(rd, ext_exp());
        FLASH_ERASE_DONE <= 1'b1;
        @(posedge CLK);
        FLASH_ERASE_DONE <= 1'b0;
        busy = 1'b0;
        step(2);
        ch(1'b0, 1'b0, DRC_EXT, 32'h0);
        check(rd, ext_exp());
        ch(1'b1, 1'b1, DRC_EXT, 32'h0A000000);
        watch(0, 3, c);
        check(32'(c), 32'h0);
        ch(1'b1, 1'b1, DRC_CFG2, 32'h3B000000);
        watch(2, 3, c);
        check(32'(c), 32'h1);
        check(32'(HALT_AFTER_RESET), 32'h0);
        ch(1'b1, 1'b1, DRC_EXT, 32'h01000000);
        ch(1'b1, 1'b1, DRC_CFG2, 32'h3A000000);
        hexp = 4'hF;
        step(2);
        check(32'(HALT_AFTER_RESET), 32'hF);
        wd = $urandom & 32'hFFFFFFBF;
        c2low = wd[23:0] & CFG2_LOW_WMASK;
        ch(1'b1, 1'b0, DRC_CFG2, wd);
        sup(1'b1, DRC_CFG2, 32'hFFFFFFFF);
        check(32'(CFG2_LOW & CFG2_LOW_WMASK), 32'(c2low));
        sup(1'b0, DRC_CFG2, 32'h0);
        check(rd & 32'hFFFF00FF, cfg2_exp());
        ch(1'b0, 1'b0, DRC_CFG2, 32'h0);
        check(rd & 32'hFFFF00FF, cfg2_exp());
        ch(1'b0, 1'b1, DRC_CFG2, 32'h0);
        check(rd, cfg2_exp() & 32'hFF000000);
        RST_N <= 1'b0;
        BACKGROUND_PIN_LEVEL <= 1'b0;
        step(2);
        RST_N <= 1'b1;
        step(3);
        check(32'(HALT_AFTER_RESET), 32'hF);
        check(32'(DEBUG_CLK_SYNC), 32'h0);
        POR_N <= 1'b0;
        step(1);
        POR_N <= 1'b1;
        step(2);
        check(32'(HALT_AFTER_RESET), 32'h0);
        BRANCH_TARGET_3B <= 1'b1;
        ch(1'b1, 1'b0, DRC_CFG2, 32'h40);
        for (int s = 0; s < 4; s++) begin
            ch(1'b1, 1'b0, DRC_EXT, 32'(4 + s));
            gap(n);
            check(32'(n), 32'((2 << s) * SYNC_BASE_CYCLES / 16));
        end
        check(32'(PC_SYNC_3BYTE), 32'h1);
        ch(1'b1, 1'b0, DRC_CFG2, 32'h0);
        ch(1'b1, 1'b0, DRC_EXT, 32'h4);
        gap(n);
        check(32'(n), 32'h00000800);
        ch(1'b1, 1'b0, DRC_EXT, 32'h0);
        watch(1, 2100, c);
        check(32'(c), 32'h0);
        report_and_stop();
    end
endmodule
